// *** core/uafl_core.sv ***
// uafl_core: transmit/receive fifos, dma ready pins, prioritised interrupt
// source register and line format register of the uart.
// assumes a serializer outside that pops tx chars, pushes rx chars and
// gives one BIT_TICK_IN pulse per serial bit time.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
module uafl_core (
	// clock and reset
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	// register port
	input wire logic [2:0] ADDR_IN,
	input wire logic [7:0] WR_DATA_IN,
	input wire logic WR_STROBE_IN,
	input wire logic RD_STROBE_IN,
	output logic [7:0] RD_DATA_OUT,
	// serializer side
	output logic [7:0] TX_DATA_OUT,
	output logic TX_VALID_OUT,
	input wire logic TX_READY_IN,
	input wire logic [7:0] RX_DATA_IN,
	input wire logic RX_VALID_IN,
	input wire logic BIT_TICK_IN,
	input wire uafl_pkg::uafl_link_evt_t LINK_EVT_IN,
	output uafl_pkg::uafl_line_fmt_t LINE_FMT_OUT,
	// dma and interrupt pins
	output logic TX_DMA_READY_N_OUT,
	output logic RX_DMA_READY_N_OUT,
	output logic IRQ_OUT
);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ier_q, lcr_q, efr_q;
	logic fifo_en_q, dma_mode_q;
	logic [1:0] tx_trig_sel_q, rx_trig_sel_q;
	logic wr_data, wr_ier, wr_fcr, wr_lcr, wr_efr, wr_clr, rd_data, rd_isr;
	logic enh, blk_mode, fifo_toggle;

	assign wr_data = WR_STROBE_IN && ADDR_IN == uafl_pkg::OFS_DATA;
	assign wr_ier = WR_STROBE_IN && ADDR_IN == uafl_pkg::OFS_IRQ_EN;
	assign wr_fcr = WR_STROBE_IN && ADDR_IN == uafl_pkg::OFS_SRC_FCTL;
	assign wr_lcr = WR_STROBE_IN && ADDR_IN == uafl_pkg::OFS_LINE_FMT;
	assign wr_efr = WR_STROBE_IN && ADDR_IN == uafl_pkg::OFS_ENH;
	assign wr_clr = WR_STROBE_IN && ADDR_IN == uafl_pkg::OFS_EVT_CLR;
	assign rd_data = RD_STROBE_IN && ADDR_IN == uafl_pkg::OFS_DATA;
	assign rd_isr = RD_STROBE_IN && ADDR_IN == uafl_pkg::OFS_SRC_FCTL;
	assign enh = efr_q[uafl_pkg::EFR_ENH];
	assign blk_mode = fifo_en_q && dma_mode_q;
	// a change of fifo enable flushes both fifos so depth limits stay honest
	assign fifo_toggle = wr_fcr && (WR_DATA_IN[uafl_pkg::FCR_FIFO_EN] != fifo_en_q);

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ier_q <= uafl_pkg::IER_RST;
			lcr_q <= uafl_pkg::LCR_RST;
			efr_q <= uafl_pkg::EFR_RST;
		end else begin
			if (wr_ier) ier_q <= WR_DATA_IN;
			if (wr_lcr) lcr_q <= WR_DATA_IN;
			if (wr_efr) efr_q <= WR_DATA_IN;
		end
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			fifo_en_q <= 1'b0;
			dma_mode_q <= 1'b0;
			tx_trig_sel_q <= uafl_pkg::TRIG_SEL_RST;
			rx_trig_sel_q <= uafl_pkg::TRIG_SEL_RST;
		end else if (wr_fcr) begin
			fifo_en_q <= WR_DATA_IN[uafl_pkg::FCR_FIFO_EN];
			// other fields only take effect alongside fifo enable
			if (WR_DATA_IN[uafl_pkg::FCR_FIFO_EN]) begin
				dma_mode_q <= WR_DATA_IN[uafl_pkg::FCR_DMA];
				tx_trig_sel_q <= WR_DATA_IN[uafl_pkg::FCR_TXT_LO +: 2];
				rx_trig_sel_q <= WR_DATA_IN[uafl_pkg::FCR_RXT_LO +: 2];
			end
		end
	end

	// ****************************************
	// line format
	// ****************************************
	logic [1:0] len_sel;
	assign len_sel = lcr_q[uafl_pkg::LCR_LEN_LO +: 2];
	// one process drives every field so the port has a single driver
	always_comb begin
		LINE_FMT_OUT.data_bits = uafl_pkg::MIN_DATA_BITS + {2'b00, len_sel};
		LINE_FMT_OUT.parity_en = lcr_q[uafl_pkg::LCR_PAR];
		if (!lcr_q[uafl_pkg::LCR_STOP]) LINE_FMT_OUT.stop_half_bits = uafl_pkg::STOP_HALF_ONE;
		else if (len_sel == 2'h0) LINE_FMT_OUT.stop_half_bits = uafl_pkg::STOP_HALF_ONE_HALF;
		else LINE_FMT_OUT.stop_half_bits = uafl_pkg::STOP_HALF_TWO;
	end

	// ****************************************
	// fifos
	// ****************************************
	// with fifos off each side behaves as a single holding register
	logic [7:0] tx_mem [16];
	logic [7:0] rx_mem [16];
	logic [3:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
	logic [4:0] tx_cnt_q, rx_cnt_q, cap, tx_trig, rx_trig;
	logic tx_push, tx_pop, rx_push, rx_pop, rx_overrun, tx_clr, rx_clr;

	assign cap = fifo_en_q ? uafl_pkg::FIFO_DEPTH : uafl_pkg::SINGLE_DEPTH;
	assign tx_trig = fifo_en_q ? uafl_pkg::trig_level(tx_trig_sel_q) : uafl_pkg::TRIG_L0;
	assign rx_trig = fifo_en_q ? uafl_pkg::trig_level(rx_trig_sel_q) : uafl_pkg::TRIG_L0;
	assign tx_clr = fifo_toggle || (wr_fcr && WR_DATA_IN[uafl_pkg::FCR_FIFO_EN] && WR_DATA_IN[uafl_pkg::FCR_TX_RST]);
	assign rx_clr = fifo_toggle || (wr_fcr && WR_DATA_IN[uafl_pkg::FCR_FIFO_EN] && WR_DATA_IN[uafl_pkg::FCR_RX_RST]);
	// a write into a full tx fifo is dropped
	assign tx_push = wr_data && tx_cnt_q != cap;
	assign tx_pop = TX_VALID_OUT && TX_READY_IN;
	assign TX_VALID_OUT = tx_cnt_q != 5'h00;
	assign TX_DATA_OUT = tx_mem[tx_rp_q];
	assign rx_push = RX_VALID_IN && rx_cnt_q != cap;
	assign rx_overrun = RX_VALID_IN && rx_cnt_q == cap;
	assign rx_pop = rd_data && rx_cnt_q != 5'h00;

	always_ff @(posedge MCLK_IN) begin
		if (tx_push) tx_mem[tx_wp_q] <= WR_DATA_IN;
		if (rx_push) rx_mem[rx_wp_q] <= RX_DATA_IN;
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tx_wp_q <= 4'h0;
			tx_rp_q <= 4'h0;
			tx_cnt_q <= 5'h00;
		end else if (tx_clr) begin
			tx_wp_q <= 4'h0;
			tx_rp_q <= 4'h0;
			tx_cnt_q <= 5'h00;
		end else begin
			if (tx_push) tx_wp_q <= tx_wp_q + 4'h1;
			if (tx_pop) tx_rp_q <= tx_rp_q + 4'h1;
			tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
		end
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rx_wp_q <= 4'h0;
			rx_rp_q <= 4'h0;
			rx_cnt_q <= 5'h00;
		end else if (rx_clr) begin
			rx_wp_q <= 4'h0;
			rx_rp_q <= 4'h0;
			rx_cnt_q <= 5'h00;
		end else begin
			if (rx_push) rx_wp_q <= rx_wp_q + 4'h1;
			if (rx_pop) rx_rp_q <= rx_rp_q + 4'h1;
			rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
		end
	end

	// ****************************************
	// receive timeout
	// ****************************************
	// counted in half bit times so 1.5 stop bits stays exact
	logic [6:0] to_cnt_q, to_lim, to_next;
	logic [4:0] frame_half;
	logic to_armed, to_fire;

	assign frame_half = uafl_pkg::START_HALF + {LINE_FMT_OUT.data_bits, 1'b0}
		+ {3'b000, LINE_FMT_OUT.parity_en, 1'b0} + {2'b00, LINE_FMT_OUT.stop_half_bits};
	assign to_lim = uafl_pkg::TO_CHARS * {2'b00, frame_half};
	assign to_armed = fifo_en_q && rx_cnt_q != 5'h00 && rx_cnt_q < rx_trig;
	assign to_next = to_cnt_q + uafl_pkg::HALF_PER_TICK;
	assign to_fire = to_armed && BIT_TICK_IN && !rx_push && !rx_pop
		&& to_cnt_q < to_lim && to_next >= to_lim;

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) to_cnt_q <= 7'h00;
		else if (!to_armed || rx_push || rx_pop) to_cnt_q <= 7'h00;
		else if (BIT_TICK_IN && to_cnt_q < to_lim) to_cnt_q <= to_next;
	end

	// ****************************************
	// events and interrupt priority
	// ****************************************
	logic [6:0] ev_q, ev_set, ev_clr, act, isr_clr;
	logic [5:0] src_code;
	logic tx_below, tx_below_q, rx_lvl;

	assign tx_below = tx_cnt_q < tx_trig;
	assign rx_lvl = rx_cnt_q >= rx_trig;

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) tx_below_q <= 1'b1;
		else tx_below_q <= tx_below;
	end

	always_comb begin
		ev_set = '0;
		ev_set[uafl_pkg::EV_TX] = tx_below && !tx_below_q;
		ev_set[uafl_pkg::EV_LS] = LINK_EVT_IN.line_err || rx_overrun;
		ev_set[uafl_pkg::EV_MS] = LINK_EVT_IN.modem_chg;
		ev_set[uafl_pkg::EV_TO] = to_fire;
		ev_set[uafl_pkg::EV_XOFF] = enh && LINK_EVT_IN.xoff_rx;
		ev_set[uafl_pkg::EV_CR] = enh && LINK_EVT_IN.cts_rts_chg;
		ev_clr = isr_clr;
		if (wr_clr) ev_clr = ev_clr | WR_DATA_IN[6:0];
		// xoff is held until xon or until enhanced mode is switched off, never by a read or software clear
		ev_clr[uafl_pkg::EV_XOFF] = LINK_EVT_IN.xon_rx || !enh;
		ev_clr[uafl_pkg::EV_TO] = ev_clr[uafl_pkg::EV_TO] || rx_pop || rx_clr;
		ev_clr[uafl_pkg::EV_RX] = 1'b1;
	end

	// set wins over clear so no event is lost in a clearing cycle
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) ev_q <= '0;
		else ev_q <= (ev_q & ~ev_clr) | ev_set;
	end

	always_comb begin
		act = '0;
		act[uafl_pkg::EV_RX] = rx_lvl && ier_q[uafl_pkg::IE_RX];
		act[uafl_pkg::EV_TX] = ev_q[uafl_pkg::EV_TX] && ier_q[uafl_pkg::IE_TX];
		act[uafl_pkg::EV_LS] = ev_q[uafl_pkg::EV_LS] && ier_q[uafl_pkg::IE_LS];
		act[uafl_pkg::EV_MS] = ev_q[uafl_pkg::EV_MS] && ier_q[uafl_pkg::IE_MS];
		act[uafl_pkg::EV_TO] = ev_q[uafl_pkg::EV_TO] && ier_q[uafl_pkg::IE_RX];
		act[uafl_pkg::EV_XOFF] = enh && ev_q[uafl_pkg::EV_XOFF] && ier_q[uafl_pkg::IE_XOFF];
		act[uafl_pkg::EV_CR] = enh && ev_q[uafl_pkg::EV_CR]
			&& (ier_q[uafl_pkg::IE_RTS] || ier_q[uafl_pkg::IE_CTS]);
	end

	// rx ready is a level and drops only as the fifo drains
	always_comb begin
		isr_clr = '0;
		src_code = uafl_pkg::SRC_NONE;
		if (act[uafl_pkg::EV_LS]) begin
			src_code = uafl_pkg::SRC_LS;
			isr_clr[uafl_pkg::EV_LS] = rd_isr;
		end else if (act[uafl_pkg::EV_RX]) begin
			src_code = uafl_pkg::SRC_RX_DMA_READY_N;
		end else if (act[uafl_pkg::EV_TO]) begin
			src_code = uafl_pkg::SRC_RXTO;
			isr_clr[uafl_pkg::EV_TO] = rd_isr;
		end else if (act[uafl_pkg::EV_TX]) begin
			src_code = uafl_pkg::SRC_THRE;
			isr_clr[uafl_pkg::EV_TX] = rd_isr;
		end else if (act[uafl_pkg::EV_MS]) begin
			src_code = uafl_pkg::SRC_MODEM;
			isr_clr[uafl_pkg::EV_MS] = rd_isr;
		end else if (act[uafl_pkg::EV_XOFF]) begin
			src_code = uafl_pkg::SRC_XOFF;
		end else if (act[uafl_pkg::EV_CR]) begin
			src_code = uafl_pkg::SRC_CTSRTS;
			isr_clr[uafl_pkg::EV_CR] = rd_isr;
		end
	end

	assign IRQ_OUT = |act;

	// ****************************************
	// read data and dma pins
	// ****************************************
	logic [7:0] rd_d;
	always_comb begin
		rd_d = 8'h00;
		if (RD_STROBE_IN) begin
			unique case (ADDR_IN)
				uafl_pkg::OFS_DATA: rd_d = rx_cnt_q != 5'h00 ? rx_mem[rx_rp_q] : 8'h00;
				uafl_pkg::OFS_IRQ_EN: rd_d = ier_q;
				uafl_pkg::OFS_SRC_FCTL: rd_d = {fifo_en_q, fifo_en_q, src_code};
				uafl_pkg::OFS_LINE_FMT: rd_d = lcr_q;
				uafl_pkg::OFS_ENH: rd_d = efr_q;
				uafl_pkg::OFS_EVT_STAT: rd_d = {1'b0, ev_q[6:1], rx_lvl};
				default: rd_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) RD_DATA_OUT <= 8'h00;
		else RD_DATA_OUT <= rd_d;
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) TX_DMA_READY_N_OUT <= 1'b0;
		else if (blk_mode) TX_DMA_READY_N_OUT <= tx_cnt_q == uafl_pkg::FIFO_DEPTH;
		else TX_DMA_READY_N_OUT <= tx_cnt_q != 5'h00;
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) RX_DMA_READY_N_OUT <= 1'b1;
		else if (!blk_mode) RX_DMA_READY_N_OUT <= rx_cnt_q == 5'h00;
		else if (rx_cnt_q == 5'h00) RX_DMA_READY_N_OUT <= 1'b1;
		else if (rx_lvl || ev_q[uafl_pkg::EV_TO]) RX_DMA_READY_N_OUT <= 1'b0;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!NRST_IN);

	sequence s_isr_read;
		RD_STROBE_IN && ADDR_IN == uafl_pkg::OFS_SRC_FCTL;
	endsequence
	sequence s_ls_top;
		act[uafl_pkg::EV_LS] && !ev_set[uafl_pkg::EV_LS];
	endsequence
	sequence s_tx_at_trig;
		tx_cnt_q >= tx_trig;
	endsequence

	a_tx_single_empty: assert property (!blk_mode && tx_cnt_q == 5'h00 |=> !TX_DMA_READY_N_OUT)
		else $error("tx dma ready not low while empty");
	a_tx_single_load: assert property (!blk_mode && $rose(tx_cnt_q != 5'h00) |=> TX_DMA_READY_N_OUT)
		else $error("tx dma ready not high after load");
	a_rx_single_ready: assert property (!blk_mode |=> RX_DMA_READY_N_OUT == ($past(rx_cnt_q) == 5'h00))
		else $error("rx dma ready wrong in single mode");
	a_tx_block_full: assert property (blk_mode |=> TX_DMA_READY_N_OUT == ($past(tx_cnt_q) == uafl_pkg::FIFO_DEPTH))
		else $error("tx dma ready wrong in block mode");
	a_rx_block_hold: assert property (blk_mode && !RX_DMA_READY_N_OUT && rx_cnt_q != 5'h00 |=> !RX_DMA_READY_N_OUT)
		else $error("rx dma ready left early");
	a_rx_level_irq: assert property (ier_q[0] && rx_cnt_q >= rx_trig |-> IRQ_OUT)
		else $error("rx level interrupt missing");
	a_isr_top_clear: assert property (s_isr_read ##0 s_ls_top |=> !ev_q[uafl_pkg::EV_LS] ##0 RD_DATA_OUT[5:0] == 6'h06)
		else $error("line status not reported or cleared");
	a_isr_keep_lower: assert property (s_isr_read ##0 s_ls_top ##0 ev_q[uafl_pkg::EV_MS] |=> ev_q[uafl_pkg::EV_MS])
		else $error("lower source cleared by read");
	a_isr_idle_bit: assert property (s_isr_read |=> RD_DATA_OUT[0] == !$past(IRQ_OUT))
		else $error("pending bit wrong");
	a_isr_fifo_bits: assert property (s_isr_read |=> RD_DATA_OUT[7:6] == {2{$past(fifo_en_q)}})
		else $error("fifo bits wrong");
	a_enh_gate: assert property (!enh |-> !act[uafl_pkg::EV_XOFF] && !act[uafl_pkg::EV_CR])
		else $error("enhanced source without enable");
	a_stop_len: assert property (lcr_q[2] && lcr_q[1:0] != 2'h0 |-> LINE_FMT_OUT.stop_half_bits == 3'h4)
		else $error("stop length wrong");
	a_stop_one: assert property (!lcr_q[2] |-> LINE_FMT_OUT.stop_half_bits == 3'h2)
		else $error("single stop bit wrong");
	a_stop_half: assert property (lcr_q[2] && lcr_q[1:0] == 2'h0 |-> LINE_FMT_OUT.stop_half_bits == 3'h3)
		else $error("one and a half stop bits wrong");
	a_len_eight: assert property (lcr_q[1:0] == 2'h3 |-> LINE_FMT_OUT.data_bits == 4'h8)
		else $error("word length wrong");
	a_parity_bit: assert property (LINE_FMT_OUT.parity_en == lcr_q[3])
		else $error("parity enable wrong");
	a_tx_below_evt: assert property (s_tx_at_trig ##1 tx_cnt_q < tx_trig && $stable(tx_trig)
		|=> ev_q[uafl_pkg::EV_TX])
		else $error("tx empty event missing");
	a_rx_fill_on: assert property (fifo_en_q && RX_VALID_IN && !RD_STROBE_IN && !WR_STROBE_IN
		&& rx_cnt_q < uafl_pkg::FIFO_DEPTH |=> rx_cnt_q == $past(rx_cnt_q) + 5'h01)
		else $error("rx char not stored below full");
	a_irq_all_off: assert property (ier_q == 8'h00 |-> !IRQ_OUT)
		else $error("interrupt with all enables off");
	a_to_armed: assert property ($rose(ev_q[uafl_pkg::EV_TO])
		|-> $past(rx_cnt_q) != 5'h00 && $past(rx_cnt_q) < $past(rx_trig))
		else $error("timeout outside armed window");
	a_xoff_hold: assert property (enh && ev_q[uafl_pkg::EV_XOFF] && !LINK_EVT_IN.xon_rx
		|=> ev_q[uafl_pkg::EV_XOFF])
		else $error("xoff source dropped before xon");
	a_isr_timeout: assert property (s_isr_read ##0 act == 7'h10 && !ev_set[uafl_pkg::EV_TO]
		|=> RD_DATA_OUT[5:0] == 6'h0C && !ev_q[uafl_pkg::EV_TO])
		else $error("timeout not reported or cleared");
	a_isr_lowest: assert property (s_isr_read ##0 act == 7'h40 |=> RD_DATA_OUT[5:0] == 6'h20)
		else $error("cts rts code wrong");

endmodule // uafl_core

// *** core/uafl_pkg.sv ***
// uafl_pkg: constants, field positions, interrupt codes and carrier types
// for the uart fifo, interrupt and line format block.
// assumes one 40 MHz clock domain; no imports anywhere, all uses are scoped.
package uafl_pkg;

	// ****************************************
	// register offsets and bus widths
	// ****************************************
	localparam int unsigned ADDR_W = 3;
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_IRQ_EN = 3'h1;
	localparam logic [2:0] OFS_SRC_FCTL = 3'h2;
	localparam logic [2:0] OFS_LINE_FMT = 3'h3;
	localparam logic [2:0] OFS_ENH = 3'h4;
	localparam logic [2:0] OFS_EVT_STAT = 3'h5;
	localparam logic [2:0] OFS_EVT_CLR = 3'h6;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned FCR_FIFO_EN = 0;
	localparam int unsigned FCR_RX_RST = 1;
	localparam int unsigned FCR_TX_RST = 2;
	localparam int unsigned FCR_DMA = 3;
	localparam int unsigned FCR_TXT_LO = 4;
	localparam int unsigned FCR_RXT_LO = 6;
	localparam int unsigned LCR_LEN_LO = 0;
	localparam int unsigned LCR_STOP = 2;
	localparam int unsigned LCR_PAR = 3;
	localparam int unsigned EFR_ENH = 4;
	localparam int unsigned IE_RX = 0;
	localparam int unsigned IE_TX = 1;
	localparam int unsigned IE_LS = 2;
	localparam int unsigned IE_MS = 3;
	localparam int unsigned IE_XOFF = 5;
	localparam int unsigned IE_RTS = 6;
	localparam int unsigned IE_CTS = 7;

	// event status bit positions
	localparam int unsigned EV_RX = 0;
	localparam int unsigned EV_TX = 1;
	localparam int unsigned EV_LS = 2;
	localparam int unsigned EV_MS = 3;
	localparam int unsigned EV_TO = 4;
	localparam int unsigned EV_XOFF = 5;
	localparam int unsigned EV_CR = 6;
	localparam int unsigned EV_W = 7;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] IER_RST = 8'h00;
	localparam logic [7:0] LCR_RST = 8'h00;
	localparam logic [7:0] EFR_RST = 8'h00;
	localparam logic [1:0] TRIG_SEL_RST = 2'h0;

	// ****************************************
	// interrupt source codes, bits 5..0
	// ****************************************
	localparam logic [5:0] SRC_LS = 6'h06;
	localparam logic [5:0] SRC_RX_DMA_READY_N = 6'h04;
	localparam logic [5:0] SRC_RXTO = 6'h0C;
	localparam logic [5:0] SRC_THRE = 6'h02;
	localparam logic [5:0] SRC_MODEM = 6'h00;
	localparam logic [5:0] SRC_XOFF = 6'h10;
	localparam logic [5:0] SRC_CTSRTS = 6'h20;
	localparam logic [5:0] SRC_NONE = 6'h01;

	// ****************************************
	// fifo, trigger and frame timing
	// ****************************************
	localparam logic [4:0] FIFO_DEPTH = 5'h10;
	localparam logic [4:0] SINGLE_DEPTH = 5'h01;
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0E;
	localparam logic [3:0] MIN_DATA_BITS = 4'h5;
	localparam logic [2:0] STOP_HALF_ONE = 3'h2;
	localparam logic [2:0] STOP_HALF_ONE_HALF = 3'h3;
	localparam logic [2:0] STOP_HALF_TWO = 3'h4;
	localparam logic [4:0] START_HALF = 5'h02;
	localparam logic [6:0] TO_CHARS = 7'h04;
	localparam logic [6:0] HALF_PER_TICK = 7'h02;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic [3:0] data_bits;
		logic [2:0] stop_half_bits;
		logic parity_en;
	} uafl_line_fmt_t;

	typedef struct packed {
		logic line_err;
		logic modem_chg;
		logic xoff_rx;
		logic xon_rx;
		logic cts_rts_chg;
	} uafl_link_evt_t;

	function automatic logic [4:0] trig_level(input logic [1:0] sel);
		unique case (sel)
			2'h0: trig_level = TRIG_L0;
			2'h1: trig_level = TRIG_L1;
			2'h2: trig_level = TRIG_L2;
			2'h3: trig_level = TRIG_L3;
		endcase
	endfunction

endpackage

// *** verification/uafl_core_test.sv ***
// uafl_core_test: self-checking bench for the uart fifo, interrupt and format core.
// assumes the package, the core and the serializer model are compiled first.
`timescale 1ns/100ps
module uafl_core_test;
	localparam logic [2:0] SRC = uafl_pkg::OFS_SRC_FCTL;
	localparam logic [2:0] DAT = uafl_pkg::OFS_DATA;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic stall = 1'b1;
	uafl_pkg::uafl_link_evt_t evt = '0;
	uafl_pkg::uafl_line_fmt_t fmt;
	logic [7:0] rdata, tx_data, rx_data, b;
	logic tx_valid, tx_ready, rx_valid, tick, tx_n, rx_n, irq;
	logic [7:0] exp_q[$];
	int n_fail = 0;
	int checks_done = 0;
	int lv;
	always #12.5 clk = ~clk;
	uafl_core DUT (.MCLK_IN(clk), .NRST_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdata), .WR_STROBE_IN(wr_s),
		.RD_STROBE_IN(rd_s), .RD_DATA_OUT(rdata), .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid),
		.TX_READY_IN(tx_ready), .RX_DATA_IN(rx_data), .RX_VALID_IN(rx_valid), .BIT_TICK_IN(tick),
		.LINK_EVT_IN(evt), .LINE_FMT_OUT(fmt), .TX_DMA_READY_N_OUT(tx_n), .RX_DMA_READY_N_OUT(rx_n),
		.IRQ_OUT(irq));
	uafl_serial_model far_end (.clk_in(clk), .rst_n_in(rst_n), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
		.stall_in(stall), .tx_ready_out(tx_ready), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
		.bit_tick_out(tick));
	// ******
	// compare, bus and helper tasks
	// ******
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t pin %b want %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk8(rdata, exp);
	endtask
	task automatic ev(input logic [4:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic set_stall(input logic v);
		@(posedge clk);
		stall <= v;
	endtask
	// dma pins lag the counts, so let them settle first
	task automatic pins(input logic t, input logic r);
		idle(3);
		chk1(tx_n, t);
		chk1(rx_n, r);
	endtask
	task automatic drain(input int n);
		for (int i = 0; i < 400 && far_end.got_q.size() < n; i++)
			@(negedge clk);
		while (exp_q.size() > 0)
			chk8(far_end.got_q.size() > 0 ? far_end.got_q.pop_front() : 8'hxx, exp_q.pop_front());
	endtask
	function automatic int lvl(input int s);
		return (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 14;
	endfunction
	// {parity, stop, len} to {data bits, stop half bits, parity}
	function automatic logic [7:0] fmt_exp(input logic [3:0] c);
		return {4'(c[1:0] + 5), c[2] ? ((c[1:0] == 2'h0) ? 3'h3 : 3'h4) : 3'h2, c[3]};
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ******
	// main sequence
	// ******
	initial begin
		void'($urandom(32'h9407975b));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		pins(1'b0, 1'b1);
		chk1(irq, 1'b0);
		rdc(SRC, 8'h01);
		rdc(uafl_pkg::OFS_IRQ_EN, 8'h00);
		chk8(fmt, fmt_exp(4'h0));
		rdc(3'h7, 8'h00);
		for (int c = 0; c < 16; c++) begin
			b = {4'($urandom), 4'(c)};
			wr(uafl_pkg::OFS_LINE_FMT, b);
			rdc(uafl_pkg::OFS_LINE_FMT, b);
			chk8(fmt, fmt_exp(b[3:0]));
		end
		$display("test format done");
		wr(SRC, 8'h08);
		rdc(SRC, 8'h01);
		b = $urandom;
		exp_q.push_back(b);
		wr(DAT, b);
		pins(1'b1, 1'b1);
		wr(SRC, 8'h06);
		pins(1'b1, 1'b1);
		set_stall(1'b0);
		drain(1);
		pins(1'b0, 1'b1);
		b = $urandom;
		far_end.push_char(b);
		pins(1'b0, 1'b0);
		rdc(DAT, b);
		pins(1'b0, 1'b1);
		$display("test single done");
		wr(SRC, 8'h09);
		set_stall(1'b1);
		for (int i = 0; i < 17; i++) begin
			b = $urandom;
			if (i < 16)
				exp_q.push_back(b);
			wr(DAT, b);
			if (i == 14)
				pins(1'b0, 1'b1);
		end
		pins(1'b1, 1'b1);
		set_stall(1'b0);
		drain(16);
		pins(1'b0, 1'b1);
		chk1(tx_valid, 1'b0);
		wr(uafl_pkg::OFS_IRQ_EN, 8'h01);
		for (int s = 0; s < 4; s++) begin
			lv = lvl(s);
			wr(SRC, 8'h09 | 8'(s << 6));
			for (int i = 0; i < 16; i++) begin
				b = $urandom;
				exp_q.push_back(b);
				far_end.push_char(b);
				if (i == lv - 2)
					pins(1'b0, 1'b1);
				if (i == lv - 1) begin
					pins(1'b0, 1'b0);
					chk1(irq, 1'b1);
					rdc(SRC, 8'hC4);
				end
			end
			for (int i = 0; i < 16; i++) begin
				rdc(DAT, exp_q.pop_front());
				if (i == 14)
					pins(1'b0, 1'b0);
			end
			pins(1'b0, 1'b1);
		end
		wr(SRC, 8'h49);
		b = $urandom;
		far_end.push_char(b);
		pins(1'b0, 1'b1);
		idle(400);
		pins(1'b0, 1'b0);
		rdc(SRC, 8'hCC);
		rdc(DAT, b);
		pins(1'b0, 1'b1);
		rdc(SRC, 8'hC1);
		set_stall(1'b1);
		far_end.push_char(8'h5A);
		wr(DAT, 8'hA5);
		wr(SRC, 8'h4F);
		pins(1'b0, 1'b1);
		chk1(tx_valid, 1'b0);
		rdc(DAT, 8'h00);
		$display("test block done");
		wr(uafl_pkg::OFS_IRQ_EN, 8'h02);
		for (int s = 0; s < 4; s++) begin
			wr(SRC, 8'h01 | 8'(s << 4));
			wr(uafl_pkg::OFS_EVT_CLR, 8'hFE);
			set_stall(1'b1);
			for (int i = 0; i < lvl(s); i++) begin
				b = $urandom;
				exp_q.push_back(b);
				wr(DAT, b);
			end
			chk1(irq, 1'b0);
			set_stall(1'b0);
			drain(lvl(s));
			idle(3);
			chk1(irq, 1'b1);
			rdc(SRC, 8'hC2);
			rdc(SRC, 8'hC1);
		end
		$display("test tx trigger done");
		wr(uafl_pkg::OFS_IRQ_EN, 8'h00);
		wr(uafl_pkg::OFS_ENH, 8'h10);
		wr(uafl_pkg::OFS_EVT_CLR, 8'hFE);
		ev(5'h10);
		idle(2);
		chk1(irq, 1'b0);
		rdc(uafl_pkg::OFS_EVT_STAT, 8'h04);
		wr(uafl_pkg::OFS_IRQ_EN, 8'hEF);
		idle(2);
		chk1(irq, 1'b1);
		ev(5'h08);
		ev(5'h04);
		ev(5'h01);
		rdc(SRC, 8'hC6);
		rdc(SRC, 8'hC0);
		rdc(SRC, 8'hD0);
		rdc(SRC, 8'hD0);
		ev(5'h02);
		rdc(SRC, 8'hE0);
		rdc(SRC, 8'hC1);
		chk1(irq, 1'b0);
		wr(uafl_pkg::OFS_ENH, 8'h00);
		ev(5'h01);
		rdc(SRC, 8'hC1);
		$display("test interrupts done");
		final_report;
	end
	// bound far above the roughly 1200 cycles the sequence needs
	initial begin
		repeat (30000) @(posedge clk);
		$display("BAD t=%0t watchdog expired", $time);
		n_fail++;
		final_report;
	end
endmodule // uafl_core_test

// *** verification/uafl_serial_model.sv ***
// uafl_serial_model: serializer stand-in on the far side of the fifos.
// assumes the bench drives stall_in and calls push_char from one thread.
`timescale 1ns/100ps
module uafl_serial_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// tx side
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	input wire logic stall_in,
	output logic tx_ready_out,
	// rx side
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic bit_tick_out
);
	logic [7:0] got_q[$];
	logic [1:0] tick_cnt_q;
	initial begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
	end
	// random ready so prompt and slow pops both occur
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_ready_out <= 1'b0;
			tick_cnt_q <= 2'h0;
		end else begin
			if (tx_valid_in && tx_ready_out)
				got_q.push_back(tx_data_in);
			tx_ready_out <= !stall_in && ($urandom_range(1) != 0);
			tick_cnt_q <= tick_cnt_q + 2'h1;
		end
	end
	assign bit_tick_out = (tick_cnt_q == 2'h3);
	task automatic push_char(input logic [7:0] b);
		@(posedge clk_in);
		rx_data_out <= b;
		rx_valid_out <= 1'b1;
		@(posedge clk_in);
		// released data must not keep its last value
		rx_data_out <= ~b;
		rx_valid_out <= 1'b0;
	endtask
endmodule // uafl_serial_model
